//--- rtl/nvpl_top.sv
// Purpose: per-interrupt pending and active tracking with arbitration
// Assumes: peripheral requests and core events are on CLK
// Notes:   NMI pin is asynchronous and passes three flip-flops
//
// Overview of operation
// R1 - thirty peripheral interrupts, each with priority 0..7, lower value wins
// R2 - priority splits into group and subpriority fields by a programmable point
// R3 - each interrupt is programmed as level-sensitive or pulse
// R4 - requests sampled on the rising clock edge; a detected pulse is latched
// R5 - a pulse source holds its line high for at least one clock
// R6 - a level source holds its line until serviced
// R7 - line high while not active makes the interrupt pending; in pulse mode the code sets pending only on a rising edge
// R8 - a rising edge on the line makes the interrupt pending
// R9 - set-pending bit or software trigger write makes it pending
// R10 - pending stays until service entry or a clear-pending write
// R11 - service entry removes pending and marks the interrupt active
// R12 - level return: line high gives pending, otherwise inactive
// R13 - pulse during service gives active and pending, then pending on return
// R14 - pulse with no new pulse during service goes inactive on return
// R15 - level clear-pending keeps state if line high, else goes inactive
// R16 - pulse clear-pending: pending to inactive, active-pending to active
// R17 - priorities may change while running
// R18 - one external non-maskable interrupt input besides the maskable ones
// R19 - reset clears all pending and active flags
`include "nvpl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module nvpl_top (
    input  wire logic                     CLK,
    input  wire logic                     SRST,
    input  wire logic [`NVPL_NUM_IRQ-1:0] IRQ_REQ,
    input  wire logic                     NMI_PIN,
    input  wire logic                     NMI_ACK,
    input  wire logic                     ENTRY_VALID,
    input  wire logic [4:0]               ENTRY_NUM,
    input  wire logic                     RETURN_VALID,
    input  wire logic [4:0]               RETURN_NUM,
    input  wire logic [`NVPL_ADDR_W-1:0]  REG_ADDR,
    input  wire logic [31:0]              REG_WDATA,
    input  wire logic                     REG_WR,
    input  wire logic                     REG_RD,
    output logic      [31:0]              REG_RDATA,
    output logic      [`NVPL_NUM_IRQ-1:0] PEND_OUT,
    output logic      [`NVPL_NUM_IRQ-1:0] ACTIVE_OUT,
    output logic                          BEST_VALID,
    output logic      [4:0]               BEST_NUM,
    output logic      [`NVPL_PRIO_W-1:0]  BEST_PRIO,
    output logic      [`NVPL_PRIO_W-1:0]  BEST_GROUP,
    output logic                          NMI_PEND,
    output logic                          IRQ
);

    localparam int N = `NVPL_NUM_IRQ;

    nvpl_pkg::nvpl_state_t r;
    nvpl_pkg::nvpl_state_t n;

    logic [N-1:0]          nx_pend;
    logic [N-1:0]          nx_act;
    logic [N-1:0]          hw_new;
    logic [N-1:0]          bad_entry;
    nvpl_pkg::nvpl_prio_t  nx_prio [N];

    logic                  wr_set;
    logic                  wr_clr;
    logic                  wr_trig;

    assign wr_set  = REG_WR && (REG_ADDR == `NVPL_OFS_SETPEND);
    assign wr_clr  = REG_WR && (REG_ADDR == `NVPL_OFS_CLRPEND);
    assign wr_trig = REG_WR && (REG_ADDR == `NVPL_OFS_SOFTWARE_TRIGGER_REGISTER);

    // ----------------------------------------------------------------
    // per-interrupt state
    // ----------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_irq
        logic line;
        logic rise;
        logic pulse;
        logic entry;
        logic ret;
        logic sw_set;
        logic clr_eff;
        logic hw_set;
        logic prio_wr;

        assign line  = IRQ_REQ[i];
        assign rise  = line & ~r.prev[i]; // R4
        assign pulse = r.mode[i]; // R3
        assign entry = ENTRY_VALID && (ENTRY_NUM == 5'(i));
        assign ret   = RETURN_VALID && (RETURN_NUM == 5'(i));

        assign sw_set = (wr_set && REG_WDATA[i]) || (wr_trig && (REG_WDATA[4:0] == 5'(i))); // R9

        // level: clear only takes hold once the line is down
        assign clr_eff = wr_clr && REG_WDATA[i] && (pulse || !line); // R15 R16

        // level: high while inactive, or sampled high at return
        assign hw_set = pulse ? rise : (rise || (line && (!r.act[i] || ret))); // R7 R8 R12

        always_comb begin
            if (entry) begin
                nx_pend[i] = (pulse && rise) || sw_set; // R11 R13
                nx_act[i]  = 1'b1; // R11
            end else begin
                // set wins over clear; pulse pending survives return
                nx_pend[i] = (r.pend[i] && !clr_eff) || hw_set || sw_set; // R10 R13 R14 R16
                nx_act[i]  = r.act[i] && !ret; // R12 R14
            end
        end

        assign hw_new[i]    = hw_set && !r.pend[i];
        assign bad_entry[i] = entry && !r.pend[i];

        assign prio_wr = REG_WR && (REG_ADDR == (`NVPL_OFS_PRIO0 + 8'(4 * (i / `NVPL_PRIO_PER_REG))));
        assign nx_prio[i] = prio_wr ?
            REG_WDATA[(i % `NVPL_PRIO_PER_REG) * `NVPL_PRIO_FLD_W +: `NVPL_PRIO_W] : r.prio[i]; // R1 R17
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic                 found;
        nvpl_pkg::nvpl_prio_t bp;
        logic [4:0]           bn;
        logic [`NVPL_EVT_W-1:0] evt;
        found = 1'b0;
        bp    = '0;
        bn    = '0;
        evt   = '0;
        n     = r;

        n.pend = nx_pend;
        n.act  = nx_act;
        n.prev = IRQ_REQ; // R4
        for (int k = 0; k < N; k++) begin
            n.prio[k] = nx_prio[k];
        end

        if (REG_WR && (REG_ADDR == `NVPL_OFS_MODE)) begin
            n.mode = REG_WDATA[N-1:0]; // R3
        end
        if (REG_WR && (REG_ADDR == `NVPL_OFS_PRIGRP)) begin
            n.subbits = REG_WDATA[1:0]; // R2
        end
        if (REG_WR && (REG_ADDR == `NVPL_OFS_EVT_MASK)) begin
            n.mask = REG_WDATA[`NVPL_EVT_W-1:0];
        end

        // nmi pin: a change counts once stages two and three agree
        n.nmi_s1 = NMI_PIN;
        n.nmi_s2 = r.nmi_s1;
        n.nmi_s3 = r.nmi_s2;
        if (r.nmi_s2 == r.nmi_s3) begin
            n.nmi_lvl = r.nmi_s3;
        end
        evt[`NVPL_EVT_NMI] = (r.nmi_s2 == r.nmi_s3) && r.nmi_s3 && !r.nmi_lvl;
        n.nmi_pend = evt[`NVPL_EVT_NMI] || (r.nmi_pend && !NMI_ACK); // R18

        evt[`NVPL_EVT_HWPEND]   = |hw_new;
        evt[`NVPL_EVT_BADENTRY] = |bad_entry;

        // sticky events, write one to clear, a new event wins
        if (REG_WR && (REG_ADDR == `NVPL_OFS_EVT_STAT)) begin
            n.status = (r.status & ~REG_WDATA[`NVPL_EVT_W-1:0]) | evt;
        end else begin
            n.status = r.status | evt;
        end
        n.irq = |(n.status & n.mask);

        // arbitration: lowest value, ties to lowest number
        for (int k = 0; k < N; k++) begin
            if (r.pend[k] && !r.act[k] && (!found || (r.prio[k] < bp))) begin // R1
                found = 1'b1;
                bp    = r.prio[k];
                bn    = 5'(k);
            end
        end
        n.best_valid = found;
        n.best_num   = bn;
        n.best_prio  = bp;
        n.best_group = nvpl_pkg::nvpl_prio_t'(bp >> r.subbits); // R2

        // ------------------------------------------------------------
        // read decode
        // ------------------------------------------------------------
        n.rdata = '0;
        if (REG_RD) begin
            if ((REG_ADDR == `NVPL_OFS_SETPEND) || (REG_ADDR == `NVPL_OFS_CLRPEND)) begin
                n.rdata[N-1:0] = r.pend;
            end else if (REG_ADDR == `NVPL_OFS_ACTIVE) begin
                n.rdata[N-1:0] = r.act;
            end else if (REG_ADDR == `NVPL_OFS_MODE) begin
                n.rdata[N-1:0] = r.mode;
            end else if (REG_ADDR == `NVPL_OFS_PRIGRP) begin
                n.rdata[1:0] = r.subbits;
            end else if (REG_ADDR == `NVPL_OFS_EVT_STAT) begin
                n.rdata[`NVPL_EVT_W-1:0] = r.status;
            end else if (REG_ADDR == `NVPL_OFS_EVT_MASK) begin
                n.rdata[`NVPL_EVT_W-1:0] = r.mask;
            end else if ((REG_ADDR >= `NVPL_OFS_PRIO0) && (REG_ADDR[1:0] == 2'h0) &&
                         (REG_ADDR < (`NVPL_OFS_PRIO0 + 8'(4 * ((N + 7) / 8))))) begin
                for (int k = 0; k < N; k++) begin
                    if (REG_ADDR[4:2] == 3'(k / `NVPL_PRIO_PER_REG)) begin
                        n.rdata[(k % `NVPL_PRIO_PER_REG) * `NVPL_PRIO_FLD_W +: `NVPL_PRIO_W] = r.prio[k];
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            r            <= '0; // R19
            r.mode       <= `NVPL_RST_MODE;
            r.subbits    <= `NVPL_RST_PRIGRP;
            r.mask       <= `NVPL_RST_MASK;
            for (int k = 0; k < N; k++) begin
                r.prio[k] <= `NVPL_RST_PRIO;
            end
        end else begin
            r <= n;
        end
    end

    assign REG_RDATA  = r.rdata;
    assign PEND_OUT   = r.pend;
    assign ACTIVE_OUT = r.act;
    assign BEST_VALID = r.best_valid;
    assign BEST_NUM   = r.best_num;
    assign BEST_PRIO  = r.best_prio;
    assign BEST_GROUP = r.best_group;
    assign NMI_PEND   = r.nmi_pend;
    assign IRQ        = r.irq;

endmodule

`default_nettype wire

//--- rtl/nvpl_consts.svh
// Purpose: constants of the nested interrupt pending logic
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on the plain register port
`ifndef NVPL_CONSTS_SVH
`define NVPL_CONSTS_SVH

`define NVPL_NUM_IRQ      30
`define NVPL_PRIO_W       3
`define NVPL_ADDR_W       8
`define NVPL_EVT_W        3

`define NVPL_OFS_SETPEND  8'h00
`define NVPL_OFS_CLRPEND  8'h04
`define NVPL_OFS_ACTIVE   8'h08
`define NVPL_OFS_SOFTWARE_TRIGGER_REGISTER   8'h0c
`define NVPL_OFS_MODE     8'h10
`define NVPL_OFS_PRIGRP   8'h14
`define NVPL_OFS_EVT_STAT 8'h18
`define NVPL_OFS_EVT_MASK 8'h1c
`define NVPL_OFS_PRIO0    8'h20
`define NVPL_PRIO_PER_REG 8
`define NVPL_PRIO_FLD_W   4

`define NVPL_EVT_HWPEND   0
`define NVPL_EVT_NMI      1
`define NVPL_EVT_BADENTRY 2

`define NVPL_RST_MODE     30'h0000_0000
`define NVPL_RST_PRIO     3'h0
`define NVPL_RST_PRIGRP   2'h0
`define NVPL_RST_MASK     3'h0

`endif

//--- rtl/nvpl_pkg.sv
// Purpose: types of the nested interrupt pending logic
// Assumes: nvpl_consts.svh
// Notes:   one packed struct holds all state of the top
`include "nvpl_consts.svh"

package nvpl_pkg;

    typedef logic [`NVPL_NUM_IRQ-1:0] nvpl_vec_t;
    typedef logic [`NVPL_PRIO_W-1:0]  nvpl_prio_t;

    typedef struct packed {
        nvpl_vec_t                          pend;
        nvpl_vec_t                          act;
        nvpl_vec_t                          prev;
        nvpl_vec_t                          mode;
        nvpl_prio_t [`NVPL_NUM_IRQ-1:0]     prio;
        logic [1:0]                         subbits;
        logic [`NVPL_EVT_W-1:0]             status;
        logic [`NVPL_EVT_W-1:0]             mask;
        logic                               nmi_s1;
        logic                               nmi_s2;
        logic                               nmi_s3;
        logic                               nmi_lvl;
        logic                               nmi_pend;
        logic                               best_valid;
        logic [4:0]                         best_num;
        nvpl_prio_t                         best_prio;
        nvpl_prio_t                         best_group;
        logic                               irq;
        logic [31:0]                        rdata;
    } nvpl_state_t;

endpackage

//--- test/nvpl_props.sv
// Purpose: port-level checks of the interrupt pending logic
// Assumes: bound to nvpl_top, one clock domain
// Notes:   rise_v mirrors the edge detect on the request lines
`include "nvpl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module nvpl_props (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic [29:0] IRQ_REQ,
    input wire logic        NMI_PIN,
    input wire logic        NMI_ACK,
    input wire logic        ENTRY_VALID,
    input wire logic [4:0]  ENTRY_NUM,
    input wire logic        RETURN_VALID,
    input wire logic [4:0]  RETURN_NUM,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic [29:0] PEND_OUT,
    input wire logic [29:0] ACTIVE_OUT,
    input wire logic        NMI_PEND
);
    logic [29:0] prev_req;
    wire  [29:0] rise_v = IRQ_REQ & ~prev_req;
    wire         clr_w = REG_WR && REG_ADDR == `NVPL_OFS_CLRPEND;
    always_ff @(posedge CLK) prev_req <= IRQ_REQ;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_rst; $fell(SRST) |-> PEND_OUT == '0 && ACTIVE_OUT == '0; endproperty
    a_rst: assert property (p_rst) else $error("flags not clear after reset");
    property p_rise; !ENTRY_VALID |=> (PEND_OUT & $past(rise_v)) == $past(rise_v); endproperty
    a_rise: assert property (p_rise) else $error("rising request not pending");
    property p_ent; ENTRY_VALID && !rise_v[ENTRY_NUM] && !REG_WR
        |=> ACTIVE_OUT[$past(ENTRY_NUM)] && !PEND_OUT[$past(ENTRY_NUM)]; endproperty
    a_ent: assert property (p_ent) else $error("entry did not activate");
    property p_ret; RETURN_VALID |=> !ACTIVE_OUT[$past(RETURN_NUM)]; endproperty
    a_ret: assert property (p_ret) else $error("return left interrupt active");
    property p_set; REG_WR && REG_ADDR == `NVPL_OFS_SETPEND && !ENTRY_VALID
        |=> (PEND_OUT & $past(REG_WDATA[29:0])) == $past(REG_WDATA[29:0]); endproperty
    a_set: assert property (p_set) else $error("set-pending write lost");
    property p_clr; clr_w && IRQ_REQ == '0 |=> (PEND_OUT & $past(REG_WDATA[29:0])) == '0; endproperty
    a_clr: assert property (p_clr) else $error("clear-pending write ignored");
    property p_hold; !ENTRY_VALID && !clr_w |=> (PEND_OUT & $past(PEND_OUT)) == $past(PEND_OUT); endproperty
    a_hold: assert property (p_hold) else $error("pending dropped by itself");
    property p_nmi; $rose(NMI_PIN) && !NMI_ACK |-> ##[1:6] NMI_PEND; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi edge not pending");
endmodule
bind nvpl_top nvpl_props u_props (.*);
`default_nettype wire

//--- test/nvpl_far.sv
// Purpose: far side: peripheral request lines and core entry and return
// Assumes: signals change right after rising edges of clk
// Notes:   each task returns at the falling edge after its event is taken
`timescale 1ns/1ps
`default_nettype none
module nvpl_far (
    input  wire logic        clk,
    output var  logic [29:0] irq_req,
    output var  logic        nmi_pin,
    output var  logic        nmi_ack,
    output var  logic        ent_v,
    output var  logic [4:0]  ent_n,
    output var  logic        ret_v,
    output var  logic [4:0]  ret_n
);
    initial {irq_req, nmi_pin, nmi_ack, ent_v, ent_n, ret_v, ret_n} = '0;
    // a pulse stays high one full clock; a level stays until told
    task automatic line(input int n, input logic v, input bit once);
        @(posedge clk);
        irq_req[n] <= v;
        @(posedge clk);
        if (once) irq_req[n] <= 1'b0;
        @(negedge clk);
    endtask
    task automatic core(input bit r, input logic [4:0] n);
        @(posedge clk);
        ent_v <= !r;
        ret_v <= r;
        ent_n <= n;
        ret_n <= n;
        @(posedge clk);
        ent_v <= 1'b0;
        ret_v <= 1'b0;
        @(negedge clk);
    endtask
    task automatic nmi(input logic a);
        @(posedge clk);
        nmi_pin <= 1'b1;
        nmi_ack <= a;
        @(posedge clk);
        nmi_ack <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Purpose: self-checking bench of the interrupt pending logic
// Assumes: nvpl_far plays sources and core, bench owns the register port
// Notes:   outputs are compared at falling edges
`include "nvpl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    wire logic [31:0] reg_rdata;
    wire logic [29:0] irq_req, pend_out, active_out;
    wire logic nmi_pin, nmi_ack, ent_v, ret_v, best_valid, nmi_pend, irq;
    wire logic [4:0] ent_n, ret_n, best_num;
    wire logic [2:0] best_prio, best_group;
    int fails = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    nvpl_far far (.clk(clk), .irq_req(irq_req), .nmi_pin(nmi_pin), .nmi_ack(nmi_ack),
        .ent_v(ent_v), .ent_n(ent_n), .ret_v(ret_v), .ret_n(ret_n));
    nvpl_top uut (.CLK(clk), .SRST(srst), .IRQ_REQ(irq_req), .NMI_PIN(nmi_pin), .NMI_ACK(nmi_ack),
        .ENTRY_VALID(ent_v), .ENTRY_NUM(ent_n), .RETURN_VALID(ret_v), .RETURN_NUM(ret_n),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .PEND_OUT(pend_out), .ACTIVE_OUT(active_out),
        .BEST_VALID(best_valid), .BEST_NUM(best_num), .BEST_PRIO(best_prio),
        .BEST_GROUP(best_group), .NMI_PEND(nmi_pend), .IRQ(irq));
    task automatic finish_test();
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic st(input int n, input logic [1:0] e, input string nm);
        chk({pend_out[n], active_out[n]}, e, nm);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e, nm);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(`NVPL_OFS_SETPEND, 32'h0, "pend");
        rd(`NVPL_OFS_ACTIVE, 32'h0, "act");
        rd(8'hfc, 32'h0, "unmapped");
        far.line(3, 1'b1, 1'b0);
        st(3, 2'h2, "lvl pend");
        far.core(1'b0, 5'h03);
        st(3, 2'h1, "lvl entry");
        far.core(1'b1, 5'h03);
        st(3, 2'h2, "lvl ret high");
        far.core(1'b0, 5'h03);
        far.line(3, 1'b0, 1'b0);
        far.core(1'b1, 5'h03);
        st(3, 2'h0, "lvl ret low");
        wr(`NVPL_OFS_MODE, 32'h20);
        far.line(5, 1'b1, 1'b1);
        st(5, 2'h2, "pls pend");
        far.core(1'b0, 5'h05);
        far.line(5, 1'b1, 1'b1);
        st(5, 2'h3, "pls act pend");
        far.core(1'b1, 5'h05);
        st(5, 2'h2, "pls ret");
        far.core(1'b0, 5'h05);
        far.core(1'b1, 5'h05);
        st(5, 2'h0, "pls idle");
        far.line(5, 1'b1, 1'b1);
        wr(`NVPL_OFS_CLRPEND, 32'h20);
        st(5, 2'h0, "pls clr");
        far.core(1'b0, 5'h05);
        far.line(5, 1'b1, 1'b1);
        wr(`NVPL_OFS_CLRPEND, 32'h20);
        st(5, 2'h1, "pls clr act");
        far.core(1'b1, 5'h05);
        far.line(7, 1'b1, 1'b0);
        wr(`NVPL_OFS_CLRPEND, 32'h80);
        st(7, 2'h2, "lvl clr high");
        far.line(7, 1'b0, 1'b0);
        st(7, 2'h2, "lvl stays");
        wr(`NVPL_OFS_CLRPEND, 32'h80);
        st(7, 2'h0, "lvl clr low");
        wr(`NVPL_OFS_SOFTWARE_TRIGGER_REGISTER, 32'h9);
        wr(`NVPL_OFS_SOFTWARE_TRIGGER_REGISTER, 32'h1e);
        wr(`NVPL_OFS_SETPEND, 32'h1000);
        rd(`NVPL_OFS_SETPEND, 32'h1200, "sw pend");
        wr(`NVPL_OFS_CLRPEND, 32'h1200);
        wr(`NVPL_OFS_PRIGRP, 32'h1);
        wr(`NVPL_OFS_PRIO0, 32'h670);
        wr(`NVPL_OFS_SETPEND, 32'h6);
        repeat (2) @(negedge clk);
        chk({best_valid, best_num, best_prio, best_group}, {1'b1, 5'h02, 3'h6, 3'h3}, "best");
        wr(`NVPL_OFS_PRIO0, 32'h730);
        repeat (2) @(negedge clk);
        chk({best_valid, best_num, best_prio, best_group}, {1'b1, 5'h01, 3'h3, 3'h1}, "reprio");
        wr(`NVPL_OFS_CLRPEND, 32'h6);
        wr(`NVPL_OFS_EVT_MASK, 32'h1);
        chk(irq, 1'b1, "irq on");
        wr(`NVPL_OFS_EVT_MASK, 32'h0);
        chk(irq, 1'b0, "irq masked");
        wr(`NVPL_OFS_EVT_STAT, 32'h7);
        wr(`NVPL_OFS_EVT_MASK, 32'h7);
        chk(irq, 1'b0, "irq cleared");
        far.nmi(1'b0);
        chk({nmi_pend, irq}, 2'h3, "nmi");
        far.nmi(1'b1);
        chk(nmi_pend, 1'b0, "nmi ack");
        finish_test();
    end
endmodule
`default_nettype wire
